// file: logic/adc_ctrl_regs.svh
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// register indices; byte address is four times the index
`define ADC_IDX_RESULT_HIGH 8'h17
`define ADC_IDX_CONTROL 8'h18
`define ADC_IDX_REF_CHAN 8'h19
`define ADC_IDX_IRQ_STATUS 8'h1A
`define ADC_IDX_IRQ_MASK 8'h1B

// field positions
`define ADC_LOWNIB_LSB 4
`define ADC_START_BIT 3
`define ADC_CLKSEL_LSB 0
`define ADC_REFSEL_LSB 6
`define ADC_CHANSEL_LSB 0
`define ADC_IRQ_DONE_BIT 0
`define ADC_IRQ_REFERR_BIT 1

// reset values
`define ADC_RST_RESULT 12'h000
`define ADC_RST_CLKSEL 3'h0
`define ADC_RST_REFSEL 2'h0
`define ADC_RST_CHANSEL 5'h1F
`define ADC_RST_IRQ 2'h0

// reserved reference code
`define ADC_REF_RESERVED 2'h2

// converter clock half period for select code 000, in system clocks
`define ADC_DIV_HALF_MAX 8'h80

`endif

// file: logic/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LAUNCH = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_state_t;

  // reference select codes
  typedef enum logic [1:0] {
    REF_SUPPLY = 2'b00,
    REF_BANDGAP_248 = 2'b01,
    REF_RESERVED = 2'b10,
    REF_BANDGAP_200 = 2'b11
  } ref_code_t;

endpackage

// file: logic/adc_sync.sv
`timescale 1ns/1ps

module adc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // asynchronous input and its synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two flip-flops; the first is read only by the second
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// file: logic/adc_clock_divider.sv
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_clock_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic enable,
  input wire logic [2:0] clock_select,
  // divided converter clock
  output logic div_clk
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic div_clk_q;
  logic div_clk_d;
  logic [7:0] half_m1;

  // half period minus one: 127 for code 000 down to 0 for code 111
  assign half_m1 = (`ADC_DIV_HALF_MAX >> clock_select) - 8'h01;

  // count half periods and toggle; idle holds the clock low
  always_comb
  begin
    count_d = count_q;
    div_clk_d = div_clk_q;
    if (!enable)
    begin
      count_d = 8'h00;
      div_clk_d = 1'b0;
    end
    else if (count_q >= half_m1)
    begin
      count_d = 8'h00;
      div_clk_d = ~div_clk_q;
    end
    else
    begin
      count_d = count_q + 8'h01;
    end
  end

  // register divider state
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      count_q <= 8'h00;
      div_clk_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      div_clk_q <= div_clk_d;
    end
  end

  assign div_clk = div_clk_q;

endmodule

// file: logic/adc_control_interface.sv
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_control_interface (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // analog conversion core
  output logic conv_clk,
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic [1:0] conv_reference,
  input wire logic conv_done,
  input wire logic [11:0] conv_result
);

  // bus handshake state
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic [7:0] index;
  logic wr_take;
  logic wr_lane0;
  logic [7:0] wbyte;

  // configuration registers
  logic [2:0] clk_sel_q;
  logic [2:0] clk_sel_d;
  logic [1:0] ref_sel_q;
  logic [1:0] ref_sel_d;
  logic [4:0] chan_sel_q;
  logic [4:0] chan_sel_d;
  logic [2:0] run_sel_q;
  logic [2:0] run_sel_d;
  logic [11:0] result_q;
  logic [11:0] result_d;

  // sequencer
  adc_ctrl_pkg::seq_state_t state_q;
  adc_ctrl_pkg::seq_state_t state_d;
  logic conv_start_q;
  logic conv_start_d;
  logic done_prev_q;
  logic done_prev_d;
  logic done_s;
  logic [11:0] result_s;
  logic done_rise;
  logic start_req;
  logic busy;

  // interrupts
  logic [1:0] irq_status_q;
  logic [1:0] irq_status_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  logic [1:0] irq_events;
  logic irq_q;
  logic irq_d;

  // byte views of the registers
  logic [7:0] result_high_byte;
  logic [7:0] control_byte;
  logic [7:0] ref_chan_byte;

  // completion strobe and result words from the analog core
  adc_sync #(
    .WIDTH(13)
  ) u_core_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({conv_done, conv_result}),
    .sync_out({done_s, result_s})
  );

  // converter clock runs only while a conversion is under way
  adc_clock_divider u_divider (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(busy),
    .clock_select(run_sel_q),
    .div_clk(conv_clk)
  );

  // request decode; the write lands on the edge after the wait cycle, while waitrequest is low
  assign req = avs_read | avs_write;
  assign index = avs_address[9:2];
  assign wr_take = avs_write & ack_q;
  assign wr_lane0 = wr_take & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign avs_waitrequest = req & ~ack_q;

  // register byte images
  assign busy = (state_q != adc_ctrl_pkg::SEQ_IDLE);
  assign result_high_byte = result_q[11:4];
  always_comb
  begin
    control_byte = 8'h00;
    control_byte[`ADC_LOWNIB_LSB +: 4] = result_q[3:0];
    control_byte[`ADC_START_BIT] = busy;
    control_byte[`ADC_CLKSEL_LSB +: 3] = clk_sel_q;
    ref_chan_byte = 8'h00;
    ref_chan_byte[`ADC_REFSEL_LSB +: 2] = ref_sel_q;
    ref_chan_byte[`ADC_CHANSEL_LSB +: 5] = chan_sel_q;
  end

  // one wait cycle per access; read data captured in that cycle
  always_comb
  begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q)
    begin
      rdata_d = 32'h0000_0000;
      unique case (index)
        `ADC_IDX_RESULT_HIGH: rdata_d[7:0] = result_high_byte;
        `ADC_IDX_CONTROL: rdata_d[7:0] = control_byte;
        `ADC_IDX_REF_CHAN: rdata_d[7:0] = ref_chan_byte;
        `ADC_IDX_IRQ_STATUS: rdata_d[1:0] = irq_status_q;
        `ADC_IDX_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // register bus handshake
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // configuration writes
  always_comb
  begin
    clk_sel_d = clk_sel_q;
    ref_sel_d = ref_sel_q;
    chan_sel_d = chan_sel_q;
    if (wr_lane0 && index == `ADC_IDX_CONTROL)
    begin
      clk_sel_d = wbyte[`ADC_CLKSEL_LSB +: 3];
    end
    if (wr_lane0 && index == `ADC_IDX_REF_CHAN)
    begin
      ref_sel_d = wbyte[`ADC_REFSEL_LSB +: 2];
      chan_sel_d = wbyte[`ADC_CHANSEL_LSB +: 5];
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      clk_sel_q <= `ADC_RST_CLKSEL;
      ref_sel_q <= `ADC_RST_REFSEL;
      chan_sel_q <= `ADC_RST_CHANSEL;
    end
    else
    begin
      clk_sel_q <= clk_sel_d;
      ref_sel_q <= ref_sel_d;
      chan_sel_q <= chan_sel_d;
    end
  end

  // selections drive the analog core directly from their registers
  assign conv_channel = chan_sel_q;
  assign conv_reference = ref_sel_q;

  // divider select frozen at launch; a mid-conversion write cannot cut a phase short
  always_comb
  begin
    run_sel_d = run_sel_q;
    if (state_q == adc_ctrl_pkg::SEQ_IDLE)
    begin
      run_sel_d = clk_sel_d;
    end
  end

  // divider select register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      run_sel_q <= `ADC_RST_CLKSEL;
    end
    else
    begin
      run_sel_q <= run_sel_d;
    end
  end

  // result capture; both halves move on the edge that clears the start bit
  always_comb
  begin
    result_d = result_q;
    if (state_q == adc_ctrl_pkg::SEQ_WAIT && done_rise)
    begin
      result_d = result_s;
    end
  end

  // result register; a read never sees a half-updated pair
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      result_q <= `ADC_RST_RESULT;
    end
    else
    begin
      result_q <= result_d;
    end
  end

  // a write of one to the start bit while idle launches a conversion
  assign start_req = wr_lane0 && index == `ADC_IDX_CONTROL && wbyte[`ADC_START_BIT];
  assign done_rise = done_s & ~done_prev_q;

  // sequencer: launch waits for a stale done to drop, then for a new one
  always_comb
  begin
    state_d = state_q;
    done_prev_d = done_s;
    unique case (state_q)
      adc_ctrl_pkg::SEQ_IDLE:
      begin
        if (start_req)
        begin
          state_d = adc_ctrl_pkg::SEQ_LAUNCH;
        end
      end
      adc_ctrl_pkg::SEQ_LAUNCH:
      begin
        if (!done_s)
        begin
          state_d = adc_ctrl_pkg::SEQ_WAIT;
        end
      end
      adc_ctrl_pkg::SEQ_WAIT:
      begin
        if (done_rise)
        begin
          state_d = adc_ctrl_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        state_d = adc_ctrl_pkg::SEQ_IDLE;
      end
    endcase
    conv_start_d = (state_d == adc_ctrl_pkg::SEQ_LAUNCH);
  end

  // sequencer registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= adc_ctrl_pkg::SEQ_IDLE;
      conv_start_q <= 1'b0;
      done_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      conv_start_q <= conv_start_d;
      done_prev_q <= done_prev_d;
    end
  end

  assign conv_start = conv_start_q;

  // interrupt events: conversion complete, reserved reference written
  always_comb
  begin
    irq_events = 2'b00;
    irq_events[`ADC_IRQ_DONE_BIT] = (state_q == adc_ctrl_pkg::SEQ_WAIT) && done_rise;
    irq_events[`ADC_IRQ_REFERR_BIT] = wr_lane0 && index == `ADC_IDX_REF_CHAN
      && wbyte[`ADC_REFSEL_LSB +: 2] == `ADC_REF_RESERVED;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    irq_status_d = irq_status_q;
    irq_mask_d = irq_mask_q;
    if (wr_lane0 && index == `ADC_IDX_IRQ_STATUS)
    begin
      irq_status_d = irq_status_q & ~wbyte[1:0];
    end
    if (wr_lane0 && index == `ADC_IDX_IRQ_MASK)
    begin
      irq_mask_d = wbyte[1:0];
    end
    irq_status_d = irq_status_d | irq_events;
    irq_d = |(irq_status_d & irq_mask_d);
  end

  // interrupt registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_status_q <= `ADC_RST_IRQ;
      irq_mask_q <= `ADC_RST_IRQ;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

endmodule

// file: test/adc_control_interface_asserts.sv
`timescale 1ns/1ps
module adc_control_interface_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // interrupt and core side
  input wire logic irq,
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  input wire logic [1:0] conv_reference
);
  // taken write and register index
  logic tk;
  logic [7:0] ix;
  logic start_wr;
  logic [4:0] wr_chan;
  logic [1:0] wr_ref;
  assign tk = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign ix = avs_address[9:2];
  assign start_wr = tk && ix == 8'h18 && avs_writedata[3];
  assign wr_chan = avs_writedata[4:0];
  assign wr_ref = avs_writedata[7:6];
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_chan_reset: assert property (
    $fell(reset) |-> conv_channel == 5'h1F && conv_reference == 2'h0)
    else $error("bad channel reset");
  a_chan_write: assert property (
    tk && ix == 8'h19 |=> conv_channel == $past(wr_chan) && conv_reference == $past(wr_ref))
    else $error("channel write lost");
  a_chan_hold: assert property (
    !(tk && ix == 8'h19) |=> $stable(conv_channel) && $stable(conv_reference))
    else $error("channel moved");
  a_start_cause: assert property (
    $rose(conv_start) |-> $past(start_wr))
    else $error("start without write");
  a_start_short: assert property ($rose(conv_start) |=> ##[0:4] !conv_start)
    else $error("start stuck");
  a_wait_once: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && (ix < 8'h17 || ix > 8'h1B) |-> avs_readdata == 32'h0)
    else $error("unmapped not zero");
  a_irq_masked: assert property (
    tk && ix == 8'h1B && avs_writedata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("masked irq high");
endmodule

bind adc_control_interface adc_control_interface_asserts adc_control_interface_asserts_i (
  .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .conv_start(conv_start), .conv_channel(conv_channel), .conv_reference(conv_reference));

// file: test/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  // converter controls
  input wire logic conv_clk,
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  // conversion outcome
  output logic conv_done,
  output logic [11:0] conv_result
);
  int n;
  // idle values come from the initialisers
  logic done_q = 1'b0;
  logic [11:0] res_q = 12'h000;
  // start drops done and scrambles the old value; four converter clocks finish
  always @(posedge conv_clk or posedge conv_start)
  begin
    if (conv_start)
    begin
      done_q <= 1'b0;
      res_q <= ~res_q;
      n <= 0;
    end
    else if (!done_q)
    begin
      n <= n + 1;
      if (n == 2)
        res_q <= {conv_channel, 7'h2B};
      if (n == 3)
        done_q <= 1'b1;
    end
  end
  assign conv_done = done_q;
  assign conv_result = res_q;
endmodule

// file: test/adc_control_interface_tb.sv
`timescale 1ns/1ps
module adc_control_interface_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, conv_clk, conv_start, conv_done;
  logic [4:0] conv_channel;
  logic [1:0] conv_reference;
  logic [11:0] conv_result;
  int err_total = 0;
  int n_compared = 0;
  int per = 0;
  int t_rise = 0;
  logic [7:0] q;
  logic [4:0] ch;
  logic [11:0] ex;

  adc_control_interface adc_control_interface_i (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .conv_clk(conv_clk), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_reference(conv_reference), .conv_done(conv_done), .conv_result(conv_result));
  adc_core_model adc_core_model_i (.conv_clk(conv_clk), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_result(conv_result));

  // system clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  // converter clock period in system clocks
  always @(posedge conv_clk)
  begin
    per = (int'($time) - t_rise) / 50;
    t_rise = int'($time);
  end
  // compare and count
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access, held until waitrequest is seen low; only the watchdog ends a wait
  task automatic acc(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic be);
    avs_address <= {ix, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= {3'h0, be};
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] ix);
    acc(1'b0, ix, 8'h00, 1'b1);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    acc(1'b1, ix, d, 1'b1);
  endtask
  // verdict
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #3000000;
    err_total++;
    conclude();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(8'h19);
    chk("ref_chan", 12'h01F, {4'h0, q});
    rd(8'h18);
    chk("control", 12'h000, {4'h0, q});
    wr(8'h20, 8'hFF);
    rd(8'h20);
    chk("unmapped", 12'h000, {4'h0, q});
    $display("reset test done");
    wr(8'h19, 8'hFF);
    rd(8'h19);
    chk("ref_chan", 12'h0DF, {4'h0, q});
    acc(1'b1, 8'h19, 8'h00, 1'b0);
    rd(8'h19);
    chk("byte_enable", 12'h0DF, {4'h0, q});
    wr(8'h19, 8'h80);
    rd(8'h1A);
    chk("status_ref", 12'h002, {4'h0, q});
    chk("ref_port", 12'h002, {10'h0, conv_reference});
    wr(8'h1A, 8'h02);
    rd(8'h1A);
    chk("status_clear", 12'h000, {4'h0, q});
    $display("field test done");
    for (int c = 0; c < 8; c++)
    begin
      ch = 5'(c * 3 + 1);
      ex = {ch, 7'h2B};
      wr(8'h19, {3'h2, ch});
      wr(8'h1B, {7'h00, c[0]});
      wr(8'h18, {5'h01, c[2:0]});
      rd(8'h18);
      chk("busy", {8'h00, 1'b1, c[2:0]}, {8'h00, q[3:0]});
      // a zero start written mid-conversion must not abort it
      wr(8'h18, {5'h00, c[2:0]});
      for (int k = 0; k < 1000 && q[3] !== 1'b0; k++)
        rd(8'h18);
      chk("low_nibble", {8'h00, ex[3:0]}, {8'h00, q[7:4]});
      chk("start_clear", 12'h000, {11'h0, q[3]});
      rd(8'h17);
      chk("high_byte", {4'h0, ex[11:4]}, {4'h0, q});
      chk("clk_period", 12'(256 >> c), 12'(per));
      chk("irq", {11'h0, c[0]}, {11'h0, irq});
      rd(8'h1A);
      chk("status_done", 12'h001, {4'h0, q});
      wr(8'h1A, 8'h01);
      chk("irq_clear", 12'h000, {11'h0, irq});
      $display("conversion test %0d done", c);
    end
    conclude();
  end
endmodule
